//--- design/cpsf_pkg.sv
// Constants for the communication port control and status flag bank
// Contract
// - In computer link mode each reply waits programmed value times ten milliseconds.
// - Raw character mode uses eight-bit changeable trailing code, reset value 0D hex.
// - Two-wire flag set in raw character mode selects two-wire port operation.
// - Field interface ok flag is on while field mode communication is normal.
// - Setting field startup request on starts field interface mode operation.
// - Field connected flag comes on once field connection completes normally.
// - Setting-select flag off uses defaults, on uses user settings in field mode.
// - Partner-run flag is on while data link partner reports run mode.
// - Data link ok flag is on while data link communication is normal.
// - Setting raw mode reset request on resets raw character mode operation.
// - 128 scan-ok bits, bit n on while link word n transfers normally.
package cpsf_pkg;
    localparam logic [7:0]  CPSF_OFS_DELAY   = 8'h00;
    localparam logic [7:0]  CPSF_OFS_FLAGS   = 8'h04;
    localparam logic [7:0]  CPSF_OFS_SCAN0   = 8'h10;
    localparam logic [7:0]  CPSF_OFS_SCAN7   = 8'h2C;
    localparam logic [7:0]  CPSF_OFS_IRQ_ST  = 8'h30;
    localparam logic [7:0]  CPSF_OFS_IRQ_MSK = 8'h34;
    localparam logic [7:0]  CPSF_OFS_MODE    = 8'h38;
    // Flag word bit positions
    localparam int          CPSF_B_TWO_WIRE  = 8;
    localparam int          CPSF_B_FLD_OK    = 9;
    localparam int          CPSF_B_FLD_START = 10;
    localparam int          CPSF_B_FLD_CONN  = 11;
    localparam int          CPSF_B_FLD_SET   = 12;
    localparam int          CPSF_B_PART_RUN  = 13;
    localparam int          CPSF_B_DL_OK     = 14;
    localparam int          CPSF_B_RAW_RST   = 15;
    localparam logic [7:0]  CPSF_TRAIL_RST   = 8'h0D;
    localparam logic [15:0] CPSF_DELAY_RST   = 16'h0000;
    localparam logic [15:0] CPSF_DELAY_MAX   = 16'h001E;
    // Delay unit of ten milliseconds at 200 MHz
    localparam int          CPSF_CLK_MHZ     = 200;
    localparam int          CPSF_UNIT_MS     = 10;
    localparam int          CPSF_UNIT_CYC    = CPSF_UNIT_MS * 1000 * CPSF_CLK_MHZ;
    localparam int          CPSF_WORDS       = 128;
    typedef enum logic [1:0] {
        CPSF_MODE_COMPUTER = 2'b00,
        CPSF_MODE_RAW      = 2'b01,
        CPSF_MODE_FIELD    = 2'b10,
        CPSF_MODE_DATALINK = 2'b11
    } cpsf_mode_t;
    typedef enum logic [1:0] {
        CPSF_RP_IDLE = 2'b00,
        CPSF_RP_WAIT = 2'b01,
        CPSF_RP_SEND = 2'b10
    } cpsf_reply_t;
endpackage : cpsf_pkg

//--- design/cpsf_top.sv
// Communication port flag bank with AXI4-Lite slave and reply delay timer
`timescale 1ns/1ps
module cpsf_top #(
    parameter int UNIT_CYC = cpsf_pkg::CPSF_UNIT_CYC
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Port engine status
    input  wire logic        field_comm_ok,
    input  wire logic        field_connected,
    input  wire logic        partner_run_flag,
    input  wire logic        data_link_ok,
    // Link word transfer results
    input  wire logic        scan_done,
    input  wire logic [6:0]  scan_word,
    input  wire logic        scan_good,
    // Reply request from port engine
    input  wire logic        reply_req,
    output logic             reply_go,
    // Port controls
    output logic [7:0]       trail_code,
    output logic             two_wire_en,
    output logic             field_start,
    output logic             field_user_set,
    output logic             raw_reset,
    output logic [1:0]       port_mode,
    output logic             irq
);
    logic [15:0]  delay_ff;
    logic [7:0]   trail_ff;
    logic         two_wire_ff, fld_start_ff, fld_set_ff, raw_rst_ff;
    logic [1:0]   mode_ff;
    logic [127:0] scan_ff;
    logic [3:0]   st_ff, msk_ff;
    logic [2:0]   prev_ff;
    logic         aw_got_ff, w_got_ff;
    logic [7:0]   awaddr_ff;
    logic [31:0]  wdata_ff;
    logic [3:0]   wstrb_ff;
    cpsf_pkg::cpsf_reply_t rp_ff;
    logic [31:0]  cyc_ff;
    logic [15:0]  units_ff;
    logic         reply_go_ff, irq_ff;

    function automatic logic is_scan(input logic [7:0] a);
        is_scan = a >= cpsf_pkg::CPSF_OFS_SCAN0 && a <= cpsf_pkg::CPSF_OFS_SCAN7 && a[1:0] == 2'b00;
    endfunction : is_scan

    function automatic logic [15:0] flag_word();
        logic [15:0] f;
        f = {8'h00, trail_ff};
        f[cpsf_pkg::CPSF_B_TWO_WIRE]  = two_wire_ff;
        f[cpsf_pkg::CPSF_B_FLD_OK]    = field_comm_ok;
        f[cpsf_pkg::CPSF_B_FLD_START] = fld_start_ff;
        f[cpsf_pkg::CPSF_B_FLD_CONN]  = field_connected;
        f[cpsf_pkg::CPSF_B_FLD_SET]   = fld_set_ff;
        f[cpsf_pkg::CPSF_B_PART_RUN]  = partner_run_flag;
        f[cpsf_pkg::CPSF_B_DL_OK]     = data_link_ok;
        f[cpsf_pkg::CPSF_B_RAW_RST]   = raw_rst_ff;
        flag_word = f;
    endfunction : flag_word

    // Write channel: address and data taken in either order
    logic wr_fire;
    assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;
    always_ff @(posedge clock) begin
        if (rst) begin
            aw_got_ff     <= 1'b0;
            w_got_ff      <= 1'b0;
            awaddr_ff     <= 8'h00;
            wdata_ff      <= 32'h0000_0000;
            wstrb_ff      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else begin
            s_axi_awready <= !aw_got_ff && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_got_ff && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_ff    <= 1'b0;
                w_got_ff     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_ff == cpsf_pkg::CPSF_OFS_DELAY || awaddr_ff == cpsf_pkg::CPSF_OFS_FLAGS
                                 || awaddr_ff == cpsf_pkg::CPSF_OFS_IRQ_MSK || awaddr_ff == cpsf_pkg::CPSF_OFS_MODE
                                 || awaddr_ff == cpsf_pkg::CPSF_OFS_IRQ_ST || is_scan(awaddr_ff)) ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Writable control words; read-only words ignore writes
    always_ff @(posedge clock) begin
        if (rst) begin
            delay_ff     <= cpsf_pkg::CPSF_DELAY_RST;
            trail_ff     <= cpsf_pkg::CPSF_TRAIL_RST;
            two_wire_ff  <= 1'b0;
            fld_start_ff <= 1'b0;
            fld_set_ff   <= 1'b0;
            raw_rst_ff   <= 1'b0;
            mode_ff      <= cpsf_pkg::CPSF_MODE_COMPUTER;
            msk_ff       <= 4'h0;
        end else if (wr_fire) begin
            case (awaddr_ff)
                cpsf_pkg::CPSF_OFS_DELAY: begin
                    // Stored as written; the reply timer clamps values above 30, software should keep to 0..30
                    if (wstrb_ff[0])
                        delay_ff[7:0] <= wdata_ff[7:0];
                    if (wstrb_ff[1])
                        delay_ff[15:8] <= wdata_ff[15:8];
                end
                cpsf_pkg::CPSF_OFS_FLAGS: begin
                    if (wstrb_ff[0])
                        trail_ff <= wdata_ff[7:0];
                    if (wstrb_ff[1]) begin
                        two_wire_ff  <= wdata_ff[cpsf_pkg::CPSF_B_TWO_WIRE];
                        fld_start_ff <= wdata_ff[cpsf_pkg::CPSF_B_FLD_START];
                        fld_set_ff   <= wdata_ff[cpsf_pkg::CPSF_B_FLD_SET];
                        raw_rst_ff   <= wdata_ff[cpsf_pkg::CPSF_B_RAW_RST];
                    end
                end
                cpsf_pkg::CPSF_OFS_IRQ_MSK: begin
                    if (wstrb_ff[0])
                        msk_ff <= wdata_ff[3:0];
                end
                cpsf_pkg::CPSF_OFS_MODE: begin
                    if (wstrb_ff[0])
                        mode_ff <= wdata_ff[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read channel, one outstanding read; status read clears sticky bits
    logic rd_take, rd_st;
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign rd_st   = rd_take && s_axi_araddr == cpsf_pkg::CPSF_OFS_IRQ_ST;
    always_ff @(posedge clock) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                if (is_scan(s_axi_araddr))
                    s_axi_rdata <= {16'h0000, scan_ff[{s_axi_araddr[4:2] - 3'h4, 4'h0} +: 16]};
                else begin
                    case (s_axi_araddr)
                        cpsf_pkg::CPSF_OFS_DELAY:   s_axi_rdata <= {16'h0000, delay_ff};
                        cpsf_pkg::CPSF_OFS_FLAGS:   s_axi_rdata <= {16'h0000, flag_word()};
                        cpsf_pkg::CPSF_OFS_IRQ_ST:  s_axi_rdata <= {28'h0000000, st_ff};
                        cpsf_pkg::CPSF_OFS_IRQ_MSK: s_axi_rdata <= {28'h0000000, msk_ff};
                        cpsf_pkg::CPSF_OFS_MODE:    s_axi_rdata <= {30'h0, mode_ff};
                        default: begin
                            s_axi_rdata <= 32'h0000_0000;
                            s_axi_rresp <= 2'b10;
                        end
                    endcase
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Scan map follows every transfer result, good or not
    always_ff @(posedge clock) begin
        if (rst)
            scan_ff <= '0;
        else if (scan_done)
            scan_ff[scan_word] <= scan_good;
    end

    // Events: rises of field ok, field connected, data link ok, link word fault
    logic [3:0] ev;
    assign ev = {scan_done && !scan_good,
                 data_link_ok && !prev_ff[2],
                 field_connected && !prev_ff[1],
                 field_comm_ok && !prev_ff[0]};
    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff   <= 4'h0;
            prev_ff <= 3'h0;
            irq_ff  <= 1'b0;
        end else begin
            prev_ff <= {data_link_ok, field_connected, field_comm_ok};
            // New event wins over the read clear
            st_ff   <= (rd_st ? 4'h0 : st_ff) | ev;
            irq_ff  <= |(((rd_st ? 4'h0 : st_ff) | ev) & msk_ff);
        end
    end

    // Reply timer; one ten-millisecond unit is 2000000 cycles, too many for 16 bits, hence the 32-bit cycle counter
    logic [15:0] dly_eff;
    assign dly_eff = (delay_ff > cpsf_pkg::CPSF_DELAY_MAX) ? cpsf_pkg::CPSF_DELAY_MAX : delay_ff;
    always_ff @(posedge clock) begin
        if (rst) begin
            rp_ff       <= cpsf_pkg::CPSF_RP_IDLE;
            cyc_ff      <= 32'h0000_0000;
            units_ff    <= 16'h0000;
            reply_go_ff <= 1'b0;
        end else begin
            reply_go_ff <= 1'b0;
            case (rp_ff)
                cpsf_pkg::CPSF_RP_IDLE: begin
                    if (reply_req) begin
                        cyc_ff   <= 32'h0000_0000;
                        units_ff <= dly_eff;
                        if (mode_ff == cpsf_pkg::CPSF_MODE_COMPUTER && dly_eff != 16'h0000)
                            rp_ff <= cpsf_pkg::CPSF_RP_WAIT;
                        else
                            rp_ff <= cpsf_pkg::CPSF_RP_SEND;
                    end
                end
                cpsf_pkg::CPSF_RP_WAIT: begin
                    if (cyc_ff == 32'(UNIT_CYC - 1)) begin
                        cyc_ff   <= 32'h0000_0000;
                        units_ff <= units_ff - 16'h0001;
                        if (units_ff == 16'h0001)
                            rp_ff <= cpsf_pkg::CPSF_RP_SEND;
                    end else begin
                        cyc_ff <= cyc_ff + 32'h0000_0001;
                    end
                end
                cpsf_pkg::CPSF_RP_SEND: begin
                    reply_go_ff <= 1'b1;
                    rp_ff       <= cpsf_pkg::CPSF_RP_IDLE;
                end
                default: rp_ff <= cpsf_pkg::CPSF_RP_IDLE;
            endcase
        end
    end

    // Port control outputs, each from a flop
    always_ff @(posedge clock) begin
        if (rst) begin
            trail_code     <= cpsf_pkg::CPSF_TRAIL_RST;
            two_wire_en    <= 1'b0;
            field_start    <= 1'b0;
            field_user_set <= 1'b0;
            raw_reset      <= 1'b0;
            port_mode      <= cpsf_pkg::CPSF_MODE_COMPUTER;
        end else begin
            trail_code     <= trail_ff;
            two_wire_en    <= two_wire_ff && mode_ff == cpsf_pkg::CPSF_MODE_RAW;
            field_start    <= fld_start_ff && mode_ff == cpsf_pkg::CPSF_MODE_FIELD;
            field_user_set <= fld_set_ff;
            raw_reset      <= raw_rst_ff && mode_ff == cpsf_pkg::CPSF_MODE_RAW;
            port_mode      <= mode_ff;
        end
    end
    assign reply_go = reply_go_ff;
    assign irq      = irq_ff;

    a_two_wire: assert property (@(posedge clock) disable iff (rst)
        two_wire_en |-> $past(mode_ff) == cpsf_pkg::CPSF_MODE_RAW)
        else $error("two-wire enabled outside raw mode");
    a_raw_reset: assert property (@(posedge clock) disable iff (rst)
        (raw_rst_ff && mode_ff == cpsf_pkg::CPSF_MODE_RAW) |=> raw_reset)
        else $error("raw reset request not passed on");
    a_field_start: assert property (@(posedge clock) disable iff (rst)
        (fld_start_ff && mode_ff == cpsf_pkg::CPSF_MODE_FIELD) |=> field_start)
        else $error("field start not passed on");
    a_field_set: assert property (@(posedge clock) disable iff (rst)
        field_user_set == $past(fld_set_ff))
        else $error("setting select not followed");
    a_trail_code: assert property (@(posedge clock) disable iff (rst)
        ##1 trail_code == $past(trail_ff))
        else $error("trailing code not followed");
    a_scan_update: assert property (@(posedge clock) disable iff (rst)
        scan_done |=> scan_ff[$past(scan_word)] == $past(scan_good))
        else $error("scan bit not updated");
    a_scan_clear: assert property (@(posedge clock) disable iff (rst)
        (scan_done && !scan_good) |=> !scan_ff[$past(scan_word)])
        else $error("scan bit not cleared on fault");
    sequence s_quick_req;
        rp_ff == cpsf_pkg::CPSF_RP_IDLE && reply_req && mode_ff != cpsf_pkg::CPSF_MODE_COMPUTER;
    endsequence
    sequence s_slow_req;
        rp_ff == cpsf_pkg::CPSF_RP_IDLE && reply_req && mode_ff == cpsf_pkg::CPSF_MODE_COMPUTER
        && dly_eff != 16'h0000;
    endsequence
    a_slow_req: assert property (@(posedge clock) disable iff (rst)
        s_slow_req |=> rp_ff == cpsf_pkg::CPSF_RP_WAIT)
        else $error("delayed reply did not wait");
    a_no_delay: assert property (@(posedge clock) disable iff (rst)
        s_quick_req |-> ##2 reply_go)
        else $error("reply delayed outside computer link mode");
    a_delay_wait: assert property (@(posedge clock) disable iff (rst)
        (rp_ff == cpsf_pkg::CPSF_RP_WAIT) |-> !reply_go_ff)
        else $error("reply sent during delay");
    a_status_flags: assert property (@(posedge clock) disable iff (rst)
        (rd_take && s_axi_araddr == cpsf_pkg::CPSF_OFS_FLAGS)
        |=> {s_axi_rdata[14:13], s_axi_rdata[11], s_axi_rdata[9]}
            == $past({data_link_ok, partner_run_flag, field_connected, field_comm_ok}))
        else $error("status flags do not follow inputs");
    a_reply_pulse: assert property (@(posedge clock) disable iff (rst)
        reply_go |=> !reply_go)
        else $error("reply strobe too long");
    a_scan_keep: assert property (@(posedge clock) disable iff (rst)
        !scan_done |=> scan_ff == $past(scan_ff))
        else $error("scan map changed without transfer");
    a_irq_level: assert property (@(posedge clock) disable iff (rst)
        irq == |(st_ff & $past(msk_ff)))
        else $error("interrupt not following masked status");
    a_event_sticky: assert property (@(posedge clock) disable iff (rst)
        (ev != 4'h0) |=> (st_ff & $past(ev)) == $past(ev))
        else $error("status event lost");
    a_bresp_hold: assert property (@(posedge clock) disable iff (rst)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (@(posedge clock) disable iff (rst)
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");

    // Wait measured apart from the timer counters
    logic [31:0] wait_len_ff;
    logic [15:0] wait_dly_ff;
    always_ff @(posedge clock) begin
        if (rst || rp_ff != cpsf_pkg::CPSF_RP_WAIT)
            wait_len_ff <= 32'h0000_0001;
        else
            wait_len_ff <= wait_len_ff + 32'h0000_0001;
    end
    always_ff @(posedge clock) begin
        if (rst)
            wait_dly_ff <= 16'h0000;
        else if (rp_ff == cpsf_pkg::CPSF_RP_IDLE && reply_req)
            wait_dly_ff <= dly_eff;
    end
    sequence s_wait_done;
        $past(rp_ff) == cpsf_pkg::CPSF_RP_WAIT && rp_ff == cpsf_pkg::CPSF_RP_SEND;
    endsequence
    a_delay_len: assert property (@(posedge clock) disable iff (rst)
        s_wait_done |-> wait_len_ff == 32'(wait_dly_ff * UNIT_CYC) + 32'h0000_0001)
        else $error("reply delay length wrong");
endmodule : cpsf_top

//--- tb/cpsf_engine_model.sv
// Behavioural port engine that faces the flag bank
`timescale 1ns/1ps
module cpsf_engine_model (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Bench commands
    input  wire logic        ask_reply,
    input  wire logic        ask_scan,
    input  wire logic [6:0]  ask_word,
    input  wire logic        ask_good,
    input  wire logic [3:0]  ask_status,
    // Block side
    input  wire logic        reply_go,
    output logic             reply_req,
    output logic             scan_done,
    output logic [6:0]       scan_word,
    output logic             scan_good,
    output logic [3:0]       status_lvl,
    output logic [15:0]      reply_lat,
    output logic             lat_ok
);
    logic [15:0] cnt_ff;

    // Latency counts from the cycle the request is shown
    always_ff @(posedge clock) begin
        if (rst) begin
            reply_req <= 1'b0;
            cnt_ff    <= 16'h0000;
            reply_lat <= 16'h0000;
            lat_ok    <= 1'b0;
        end else begin
            reply_req <= ask_reply;
            cnt_ff    <= reply_req ? 16'h0001 : cnt_ff + 16'h0001;
            if (ask_reply) begin
                lat_ok <= 1'b0;
            end else if (reply_go) begin
                lat_ok    <= 1'b1;
                reply_lat <= cnt_ff;
            end
        end
    end

    // Idle transfer lines toggle so stale values are never trusted
    always_ff @(posedge clock) begin
        if (rst) begin
            scan_done  <= 1'b0;
            scan_word  <= 7'h00;
            scan_good  <= 1'b0;
            status_lvl <= 4'h0;
        end else begin
            scan_done  <= ask_scan;
            scan_word  <= ask_scan ? ask_word : ~scan_word;
            scan_good  <= ask_scan ? ask_good : ~scan_good;
            status_lvl <= ask_status;
        end
    end
endmodule : cpsf_engine_model

//--- tb/cpsf_top_tb.sv
// Self-checking bench for the port flag bank
`timescale 1ns/1ps
module cpsf_top_tb;
    localparam int UNIT = 4;
    logic         clock = 1'b0, rst = 1'b1, ask_reply = 1'b0, ask_scan = 1'b0, ask_good = 1'b0;
    logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, trail_code;
    logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'hED46;
    logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, lat_ok, reply_req, reply_go, irq;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]   s_axi_bresp, s_axi_rresp, port_mode;
    logic         scan_done, scan_good, two_wire_en, field_start, field_user_set, raw_reset;
    logic [6:0]   scan_word, ask_word = 7'h00;
    logic [3:0]   st = 4'h0, lvl;
    logic [15:0]  lat;
    logic [127:0] map = '0;
    int           err_count = 0, checked = 0;

    always #2.5 clock = ~clock;

    cpsf_top #(.UNIT_CYC(UNIT)) i_dut (
        .clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .field_comm_ok(lvl[0]), .field_connected(lvl[1]), .partner_run_flag(lvl[2]),
        .data_link_ok(lvl[3]), .scan_done(scan_done), .scan_word(scan_word), .scan_good(scan_good),
        .reply_req(reply_req), .reply_go(reply_go), .trail_code(trail_code), .two_wire_en(two_wire_en),
        .field_start(field_start), .field_user_set(field_user_set), .raw_reset(raw_reset),
        .port_mode(port_mode), .irq(irq));

    cpsf_engine_model i_eng (
        .clock(clock), .rst(rst), .ask_reply(ask_reply), .ask_scan(ask_scan), .ask_word(ask_word),
        .ask_good(ask_good), .ask_status(st), .reply_go(reply_go), .reply_req(reply_req),
        .scan_done(scan_done), .scan_word(scan_word), .scan_good(scan_good), .status_lvl(lvl),
        .reply_lat(lat), .lat_ok(lat_ok));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic logic [31:0] exp_flags(input logic [15:0] w, input logic [3:0] s);
        return {16'h0000, w[15], s[3], s[2], w[12], s[1], w[10], s[0], w[8], w[7:0]};
    endfunction : exp_flags

    task automatic stop_test();
        $display("Counts: %0d checks, %0d mismatches", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tmo();
        err_count++;
        $display("ERROR %0t: wait ran out", $time);
        stop_test();
    endtask : tmo

    task automatic hs(ref logic v);
        int n = 0;
        do begin
            @(posedge clock);
            n++;
            if (n > 300) tmo();
        end while (v !== 1'b1);
    endtask : hs

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw = 1'b1;
        logic w = 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        for (int n = 0; aw || w; n++) begin
            @(posedge clock);
            if (n > 300) tmo();
            aw = aw && !s_axi_awready;
            w  = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid  <= w;
        end
        s_axi_bready <= 1'b1;
        hs(s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, r);
    endtask : wr

    task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k, input logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        hs(s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        hs(s_axi_rvalid);
        s_axi_rready  <= 1'b0;
        chk(s_axi_rresp, r);
        chk(s_axi_rdata & k, e & k);
    endtask : rdx

    task automatic reply_chk(input int e);
        ask_reply <= 1'b1;
        @(posedge clock);
        ask_reply <= 1'b0;
        hs(lat_ok);
        chk(lat, e);
    endtask : reply_chk

    initial begin
        int d;
        int m;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        chk(trail_code, 8'h0D);
        rdx(8'h04, 32'h0000_000D, '1, 2'b00);
        rdx(8'h00, 32'h0, '1, 2'b00);
        rdx(8'h3C, 32'h0, '1, 2'b10);
        wr(8'h3C, 32'h1234, 2'b10);
        $display("Test reset and unmapped done");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            d = (i == 0) ? 0 : (i == 1) ? 30 : int'(seed % 31);
            wr(8'h00, 32'(d), 2'b00);
            rdx(8'h00, 32'(d), '1, 2'b00);
            for (int j = 0; j < 4; j++) begin
                wr(8'h38, 32'(j), 2'b00);
                reply_chk((j == 0) ? 2 + UNIT * d : 2);
            end
        end
        $display("Test reply delay done");
        for (int i = 0; i < 8; i++) begin
            m = i % 4;
            seed = xs(seed);
            wr(8'h38, 32'(m), 2'b00);
            wr(8'h04, {16'h0000, seed[15:0]}, 2'b00);
            st <= seed[19:16];
            repeat (3) @(posedge clock);
            rdx(8'h04, exp_flags(seed[15:0], seed[19:16]), '1, 2'b00);
            chk(trail_code, seed[7:0]);
            chk(two_wire_en, seed[8] && m == 1);
            chk(field_start, seed[10] && m == 2);
            chk(field_user_set, seed[12]);
            chk(raw_reset, seed[15] && m == 1);
            chk(port_mode, m);
        end
        $display("Test flag word done");
        for (int i = 0; i < 400; i++) begin
            seed = xs(seed);
            ask_word <= seed[6:0];
            ask_good <= seed[7] | seed[8];
            ask_scan <= 1'b1;
            map[seed[6:0]] = seed[7] | seed[8];
            @(posedge clock);
        end
        ask_scan <= 1'b0;
        repeat (2) @(posedge clock);
        for (int k = 0; k < 8; k++) begin
            rdx(8'(16 + 4 * k), {16'h0000, map[16 * k +: 16]}, '1, 2'b00);
        end
        wr(8'h10, 32'hFFFF, 2'b00);
        rdx(8'h10, {16'h0000, map[15:0]}, '1, 2'b00);
        $display("Test scan map done");
        // Later passes run with the mask shut so the sticky bit must still appear
        for (int e = 0; e < 8; e++) begin
            wr(8'h34, (e < 4) ? 32'h1 << e : 32'h0, 2'b00);
            st <= 4'h0;
            repeat (3) @(posedge clock);
            rdx(8'h30, 32'h0, 32'hFFFF_FFF0, 2'b00);
            st <= (e % 4 == 0) ? 4'h1 : (e % 4 == 1) ? 4'h2 : (e % 4 == 2) ? 4'h8 : 4'h0;
            ask_good <= 1'b0;
            ask_scan <= (e % 4 == 3);
            @(posedge clock);
            ask_scan <= 1'b0;
            repeat (4) @(posedge clock);
            chk(irq, e < 4);
            rdx(8'h30, 32'h1 << (e % 4), 32'hF, 2'b00);
            repeat (3) @(posedge clock);
            chk(irq, 1'b0);
        end
        $display("Test interrupt done");
        stop_test();
    end
endmodule : cpsf_top_tb
